// File: anx_regs.sv
// Purpose: expansion status and transmit next-page registers
// Assumes: negotiation engine inputs are on clk_sys_i, no sync needed
// Notes:   reads return data one cycle after the read strobe
//
// How it works
// - expansion bit 6 always reads one.
// - expansion bit 5 always reads one, next pages go to index 8.
// - expansion bit 4 latches high on a parallel detection fault.
// - expansion bit 3 shows partner next-page ability, reset zero.
// - expansion bit 2 always reads one for local next-page ability.
// - expansion bit 1 latches high when a new page arrives.
// - expansion bit 0 shows partner autoneg ability, reset zero.
// - transmit bit 15 is writable, resets to zero, flags more pages.
// - transmit bit 13 is writable, resets to one, selects message page.
// - transmit bit 12 is writable, resets to zero, acknowledge 2.
// - transmit bit 11 is read only, resets zero, inverts last toggle.
// - transmit bits 10 to 0 are writable and reset to the value 1 (11'h001).
//
// Chosen here: the plain strobed port.
`default_nettype none
module anx_regs
(
  input  wire logic                  clk_sys_i,        // system clock, 10 MHz
  input  wire logic                  rst_b_i,          // reset, active low
  input  wire logic                  ce_i,             // clock enable
  input  wire anx_pkg::anx_bus_req_t bus_i,            // register request
  output var  logic [15:0]           rdata_o,          // read data, next cycle
  input  wire logic                  lp_an_able_i,     // partner autoneg able
  input  wire logic                  lp_np_able_i,     // partner can next-page
  input  wire logic                  page_rx_i,        // new page pulse
  input  wire logic                  pd_fault_i,       // parallel fault pulse
  input  wire logic                  np_sent_i,        // next page sent pulse
  input  wire logic                  np_sent_toggle_i, // toggle of page sent
  output var  anx_pkg::anx_np_tx_t   np_tx_o,          // next page to send
  output logic                       irq_o             // interrupt level
);
  import anx_pkg::*;

  logic              lp_an_reg;
  logic              lp_np_reg;
  logic              pg_rx_q;
  logic              pd_flt_q;
  logic              np_reg;
  logic              mp_reg;
  logic              ack2_reg;
  logic              tog_reg;
  logic [CODE_W-1:0] code_reg;
  logic [DATA_W-1:0] exp_val;
  logic [DATA_W-1:0] nptx_val;
  logic [DATA_W-1:0] rdata_next;
  logic [IRQ_N-1:0]  irq_ev;
  logic [IRQ_N-1:0]  irq_stat;
  logic [IRQ_N-1:0]  irq_en;
  logic              rd_exp;
  logic              wr_nptx;
  logic              wr_en;
  logic              wr_clr;

  assign rd_exp  = bus_i.rd && (bus_i.addr == IDX_EXP);
  assign wr_nptx = bus_i.wr && (bus_i.addr == IDX_NPTX);
  assign wr_en   = bus_i.wr && (bus_i.addr == IDX_IRQ_EN);
  assign wr_clr  = bus_i.wr && (bus_i.addr == IDX_IRQ_CLR);

  // partner status is sampled into flops to give it a reset value
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lp_an_reg <= 1'b0;
      lp_np_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      lp_an_reg <= lp_an_able_i;
      lp_np_reg <= lp_np_able_i;
    end
  end

  // latched-high bits; the read that returns them also clears them
  anx_lh_bit u_pg_rx
  (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .set_i     (page_rx_i),
    .clr_i     (rd_exp),
    .q_o       (pg_rx_q)
  );

  anx_lh_bit u_pd_flt
  (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .set_i     (pd_fault_i),
    .clr_i     (rd_exp),
    .q_o       (pd_flt_q)
  );

  always_comb
  begin
    exp_val              = DATA_ZERO;
    exp_val[EXP_LOC_ABL] = 1'b1;
    exp_val[EXP_NP_LOC]  = 1'b1;
    exp_val[EXP_PD_FLT]  = pd_flt_q;
    exp_val[EXP_LP_NP]   = lp_np_reg;
    exp_val[EXP_NP_ABLE] = 1'b1;
    exp_val[EXP_PG_RX]   = pg_rx_q;
    exp_val[EXP_LP_AN]   = lp_an_reg;
  end

  // transmit next-page control fields
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      np_reg   <= NPTX_NP_RST;
      mp_reg   <= NPTX_MP_RST;
      ack2_reg <= NPTX_ACK2_RST;
      code_reg <= NPTX_CODE_RST;
    end
    else if (ce_i && wr_nptx)
    begin
      np_reg   <= bus_i.wdata[NPTX_NP];
      mp_reg   <= bus_i.wdata[NPTX_MP];
      ack2_reg <= bus_i.wdata[NPTX_ACK2];
      code_reg <= bus_i.wdata[NPTX_CODE_H:0];
    end
  end

  // toggle is owned by the engine; writes to bit 11 are dropped
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tog_reg <= NPTX_TOG_RST;
    else if (ce_i && np_sent_i)
      tog_reg <= ~np_sent_toggle_i;
  end

  always_comb
  begin
    nptx_val                 = DATA_ZERO;
    nptx_val[NPTX_NP]        = np_reg;
    nptx_val[NPTX_MP]        = mp_reg;
    nptx_val[NPTX_ACK2]      = ack2_reg;
    nptx_val[NPTX_TOG]       = tog_reg;
    nptx_val[NPTX_CODE_H:0]  = code_reg;
  end

  assign np_tx_o.next_page = np_reg;
  assign np_tx_o.msg_page  = mp_reg;
  assign np_tx_o.ack2      = ack2_reg;
  assign np_tx_o.toggle    = tog_reg;
  assign np_tx_o.code      = code_reg;

  // interrupt events: latched-bit sources, partner arrival and next page sent
  always_comb
  begin
    irq_ev             = '0;
    irq_ev[IRQ_PG_RX]  = page_rx_i;
    irq_ev[IRQ_PD_FLT] = pd_fault_i;
    irq_ev[IRQ_LP_AN]  = lp_an_able_i & ~lp_an_reg;
    irq_ev[IRQ_NP_TX]  = np_sent_i;
  end

  anx_irq #(
    .N (IRQ_N)
  ) u_irq
  (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .ev_i      (irq_ev),
    .en_wr_i   (wr_en),
    .clr_wr_i  (wr_clr),
    .wdata_i   (bus_i.wdata[IRQ_N-1:0]),
    .stat_o    (irq_stat),
    .en_o      (irq_en),
    .irq_o     (irq_o)
  );

  // read mux; unmapped and write-only indices return zero
  always_comb
  begin
    rdata_next = DATA_ZERO;
    case (bus_i.addr)
      IDX_EXP:      rdata_next = exp_val;
      IDX_NPTX:     rdata_next = nptx_val;
      IDX_IRQ_STAT: rdata_next[IRQ_N-1:0] = irq_stat;
      IDX_IRQ_EN:   rdata_next[IRQ_N-1:0] = irq_en;
      default:      rdata_next = DATA_ZERO;
    endcase
  end

  // data holds until the next read so a slow sampler stays safe
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= DATA_ZERO;
    else if (ce_i && bus_i.rd)
      rdata_o <= rdata_next;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_rd_exp;
    ce_i && rd_exp;
  endsequence

  sequence s_wr_nptx;
    ce_i && wr_nptx;
  endsequence

  sequence s_quiet_clear;
    s_rd_exp ##0 (!page_rx_i && !pd_fault_i);
  endsequence

  sequence s_rd_nptx;
    ce_i && bus_i.rd && (bus_i.addr == IDX_NPTX);
  endsequence

  sequence s_pd_evt;
    ce_i && pd_fault_i;
  endsequence

  sequence s_pg_evt;
    ce_i && page_rx_i;
  endsequence

  AST_LOC_ABLE: assert property (s_rd_exp |=> rdata_o[EXP_LOC_ABL])
    else $error("location able bit read as zero");

  AST_NP_LOC: assert property (s_rd_exp |=> rdata_o[EXP_NP_LOC])
    else $error("storage location bit read as zero");

  AST_PD_FLT_SET: assert property (
    s_pd_evt |=> pd_flt_q)
    else $error("parallel fault not latched");

  AST_PD_FLT_CAUSE: assert property (
    $rose(pd_flt_q) |-> $past(pd_fault_i) && $past(ce_i))
    else $error("parallel fault bit rose without a fault");

  AST_LP_NP_RD: assert property (
    ce_i && lp_np_able_i ##1 s_rd_exp |=> rdata_o[EXP_LP_NP])
    else $error("partner next page ability not reported");

  AST_NP_ABLE: assert property (s_rd_exp |=> rdata_o[EXP_NP_ABLE])
    else $error("local next page able read as zero");

  AST_PG_RX_RD: assert property (
    ce_i && page_rx_i ##1 s_rd_exp |=> rdata_o[EXP_PG_RX])
    else $error("page received not reported");

  AST_LP_AN_RD: assert property (
    s_rd_exp |=> rdata_o[EXP_LP_AN] == $past(lp_an_reg))
    else $error("partner autoneg ability misreported");

  AST_NPTX_CTRL: assert property (
    s_wr_nptx ##1 (ce_i && bus_i.rd && bus_i.addr == IDX_NPTX)
    |=> rdata_o[NPTX_NP] == $past(bus_i.wdata[NPTX_NP], 2))
    else $error("next page bit not written");

  AST_NPTX_MP: assert property (
    s_wr_nptx |=> np_tx_o.msg_page == $past(bus_i.wdata[NPTX_MP])
               && np_tx_o.ack2 == $past(bus_i.wdata[NPTX_ACK2]))
    else $error("message page or ack2 not written");

  AST_TOGGLE: assert property (
    ce_i && np_sent_i ##1 (ce_i && bus_i.rd && bus_i.addr == IDX_NPTX)
    |=> rdata_o[NPTX_TOG] == !$past(np_sent_toggle_i, 2))
    else $error("toggle readback is not the inverse of the last sent");

  AST_CODE: assert property (
    s_wr_nptx |=> np_tx_o.code == $past(bus_i.wdata[NPTX_CODE_H:0])
               && (np_tx_o.toggle == $past(tog_reg) || $past(np_sent_i)))
    else $error("code field not written");

  AST_CLR_ON_RD: assert property (
    s_quiet_clear |=> !pg_rx_q && !pd_flt_q)
    else $error("latched bits survived a status read");

  AST_SET_WINS: assert property (
    s_rd_exp ##0 page_rx_i |=> pg_rx_q)
    else $error("page event lost in the clearing cycle");

  AST_IRQ_LEVEL: assert property (
    irq_o == |(irq_stat & irq_en))
    else $error("interrupt level does not follow status and enable");

  // a host usually leaves an idle cycle between strobes, so these forms
  // see the event, a quiet cycle and only then the read
  AST_PG_RX_GAP: assert property (
    s_pg_evt ##1 !rd_exp ##1 s_rd_exp |=> rdata_o[EXP_PG_RX])
    else $error("page received lost before the status read");

  AST_PD_FLT_GAP: assert property (
    s_pd_evt ##1 !rd_exp ##1 s_rd_exp |=> rdata_o[EXP_PD_FLT])
    else $error("parallel fault lost before the status read");

  AST_PD_SET_WINS: assert property (
    s_rd_exp ##0 pd_fault_i |=> pd_flt_q)
    else $error("parallel fault lost in the clearing cycle");

  AST_LP_NP_CLR: assert property (
    ce_i && !lp_np_able_i ##1 s_rd_exp |=> !rdata_o[EXP_LP_NP])
    else $error("partner next page ability reported while absent");

  AST_LP_AN_CLR: assert property (
    ce_i && !lp_an_able_i ##1 s_rd_exp |=> !rdata_o[EXP_LP_AN])
    else $error("partner autoneg ability reported while absent");

  AST_NPTX_GAP: assert property (
    s_wr_nptx ##1 !wr_nptx ##1 s_rd_nptx
    |=> rdata_o[NPTX_NP] == $past(bus_i.wdata[NPTX_NP], 3)
        && rdata_o[NPTX_CODE_H:0] == $past(bus_i.wdata[NPTX_CODE_H:0], 3))
    else $error("next page control word not read back");

  AST_TOG_GAP: assert property (
    ce_i && np_sent_i ##1 !np_sent_i ##1 s_rd_nptx
    |=> rdata_o[NPTX_TOG] == !$past(np_sent_toggle_i, 3))
    else $error("toggle readback lost its last sent value");

  // writes to bit 11 must never reach the toggle flop
  AST_TOG_HOLD: assert property (
    !(ce_i && np_sent_i) |=> $stable(np_tx_o.toggle))
    else $error("toggle moved without a sent page");

  AST_CE_FREEZE: assert property (
    !ce_i |=> $stable(np_tx_o) && $stable(rdata_o) && $stable(pg_rx_q)
              && $stable(pd_flt_q) && $stable(irq_stat) && $stable(irq_en))
    else $error("state moved while the clock enable was low");

  AST_IRQ_EVT: assert property (
    ce_i && pd_fault_i && irq_en[IRQ_PD_FLT] && !wr_en |=> irq_o)
    else $error("enabled parallel fault raised no interrupt");

  AST_IRQ_SET_WINS: assert property (
    ce_i && wr_clr && pd_fault_i |=> irq_stat[IRQ_PD_FLT])
    else $error("parallel fault lost under a same-cycle clear");

endmodule : anx_regs
`default_nettype wire

// File: anx_pkg.sv
// Purpose: shared constants and carriers of the autoneg expansion regs
// Assumes: 16-bit registers addressed by their register index
// Notes:   interrupt register indices are local to this block
`default_nettype none
package anx_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned IRQ_N  = 4;

  localparam logic [ADDR_W-1:0] IDX_EXP      = 5'h06;
  localparam logic [ADDR_W-1:0] IDX_NPTX     = 5'h07;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] IDX_IRQ_EN   = 5'h11;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLR  = 5'h12;

  // expansion status bit positions
  localparam int unsigned EXP_LP_AN   = 0;
  localparam int unsigned EXP_PG_RX   = 1;
  localparam int unsigned EXP_NP_ABLE = 2;
  localparam int unsigned EXP_LP_NP   = 3;
  localparam int unsigned EXP_PD_FLT  = 4;
  localparam int unsigned EXP_NP_LOC  = 5;
  localparam int unsigned EXP_LOC_ABL = 6;

  // transmit next-page bit positions
  localparam int unsigned NPTX_NP     = 15;
  localparam int unsigned NPTX_MP     = 13;
  localparam int unsigned NPTX_ACK2   = 12;
  localparam int unsigned NPTX_TOG    = 11;
  localparam int unsigned NPTX_CODE_H = 10;
  localparam int unsigned CODE_W      = 11;

  localparam logic              NPTX_NP_RST   = 1'h0;
  localparam logic              NPTX_MP_RST   = 1'h1;
  localparam logic              NPTX_ACK2_RST = 1'h0;
  localparam logic              NPTX_TOG_RST  = 1'h0;
  localparam logic [CODE_W-1:0] NPTX_CODE_RST = 11'h001;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 16'h0000;

  // interrupt status bit positions
  localparam int unsigned IRQ_PG_RX  = 0;
  localparam int unsigned IRQ_PD_FLT = 1;
  localparam int unsigned IRQ_LP_AN  = 2;
  localparam int unsigned IRQ_NP_TX  = 3;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } anx_bus_req_t;

  typedef struct packed {
    logic              next_page;
    logic              msg_page;
    logic              ack2;
    logic              toggle;
    logic [CODE_W-1:0] code;
  } anx_np_tx_t;
endpackage : anx_pkg
`default_nettype wire

// File: anx_lh_bit.sv
// Purpose: one latched-high status bit
// Assumes: set and clear are single-cycle terms on clk_sys_i
// Notes:   a set in the clearing cycle wins so no event is lost
`default_nettype none
module anx_lh_bit
(
  input  wire logic clk_sys_i, // system clock
  input  wire logic rst_b_i,   // async reset, active low
  input  wire logic ce_i,      // clock enable
  input  wire logic set_i,     // event seen
  input  wire logic clr_i,     // clear request
  output var  logic q_o        // latched state
);
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      q_o <= 1'b0;
    else if (ce_i)
      q_o <= set_i | (q_o & ~clr_i);
  end
endmodule : anx_lh_bit
`default_nettype wire

// File: anx_irq.sv
// Purpose: sticky interrupt status, enable and write-one-clear
// Assumes: events are one-cycle pulses on clk_sys_i
// Notes:   irq_o is a level, high while an enabled status bit is set
`default_nettype none
module anx_irq
#(
  parameter int unsigned N = anx_pkg::IRQ_N
)
(
  input  wire logic         clk_sys_i, // system clock
  input  wire logic         rst_b_i,   // async reset, active low
  input  wire logic         ce_i,      // clock enable
  input  wire logic [N-1:0] ev_i,      // event pulses
  input  wire logic         en_wr_i,   // enable register write
  input  wire logic         clr_wr_i,  // clear register write
  input  wire logic [N-1:0] wdata_i,   // write data
  output var  logic [N-1:0] stat_o,    // sticky status
  output var  logic [N-1:0] en_o,      // enable register
  output logic              irq_o      // interrupt level
);
  import anx_pkg::*;

  for (genvar i = 0; i < N; i++)
  begin : g_bit
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        stat_o[i] <= 1'b0;
      else if (ce_i)
        stat_o[i] <= ev_i[i] | (stat_o[i] & ~(clr_wr_i & wdata_i[i]));
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        en_o[i] <= 1'b0;
      else if (ce_i && en_wr_i)
        en_o[i] <= wdata_i[i];
    end
  end

  assign irq_o = |(stat_o & en_o);
endmodule : anx_irq
`default_nettype wire

// File: anx_lp_model.sv
// Purpose: stand-in for the link partner and the negotiation engine
// Assumes: events are one-cycle pulses on the system clock
// Notes:   ability levels hold until the bench changes them
`default_nettype none
module anx_lp_model
(
  input  wire logic clk_sys_i,  // system clock
  output var  logic an_able_o,  // partner autoneg able
  output var  logic np_able_o,  // partner next-page able
  output var  logic page_rx_o,  // page received pulse
  output var  logic pd_fault_o, // parallel fault pulse
  output var  logic np_sent_o,  // next page sent pulse
  output var  logic toggle_o    // toggle of the sent page
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    an_able_o  = 1'b0;
    np_able_o  = 1'b0;
    page_rx_o  = 1'b0;
    pd_fault_o = 1'b0;
    np_sent_o  = 1'b0;
    toggle_o   = 1'b0;
  end
  task automatic set_able(input logic an, input logic np);
    @(posedge clk_sys_i);
    an_able_o <= an;
    np_able_o <= np;
  endtask : set_able
  // toggle only qualifies np_sent_o, so it is inverted once released
  task automatic pulse(input int sel, input logic tog);
    @(posedge clk_sys_i);
    page_rx_o  <= (sel == 0);
    pd_fault_o <= (sel == 1);
    np_sent_o  <= (sel == 2);
    toggle_o   <= tog;
    @(posedge clk_sys_i);
    page_rx_o  <= 1'b0;
    pd_fault_o <= 1'b0;
    np_sent_o  <= 1'b0;
    toggle_o   <= ~tog;
  endtask : pulse
endmodule : anx_lp_model
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the autoneg expansion registers
// Assumes: one clock, read data stand in the cycle after the strobe
// Notes:   all negotiation events come from the partner model
`default_nettype none
module tb_top;
  import anx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_sys;
  logic         rst_b;
  logic         ce;
  anx_bus_req_t bus;
  logic [15:0]  rdata;
  anx_np_tx_t   np_tx;
  logic         irq;
  logic         an_able;
  logic         np_able;
  logic         page_rx;
  logic         pd_fault;
  logic         np_sent;
  logic         tog;
  int           n_errors  = 0;
  int           tests_run = 0;

  anx_regs dut
  (
    .clk_sys_i        (clk_sys),
    .rst_b_i          (rst_b),
    .ce_i             (ce),
    .bus_i            (bus),
    .rdata_o          (rdata),
    .lp_an_able_i     (an_able),
    .lp_np_able_i     (np_able),
    .page_rx_i        (page_rx),
    .pd_fault_i       (pd_fault),
    .np_sent_i        (np_sent),
    .np_sent_toggle_i (tog),
    .np_tx_o          (np_tx),
    .irq_o            (irq)
  );
  anx_lp_model lp
  (
    .clk_sys_i  (clk_sys),
    .an_able_o  (an_able),
    .np_able_o  (np_able),
    .page_rx_o  (page_rx),
    .pd_fault_o (pd_fault),
    .np_sent_o  (np_sent),
    .toggle_o   (tog)
  );

  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge clk_sys);
    bus.wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys);
    bus.rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic t_reset();
    logic [15:0] v;
    rd(IDX_EXP, v);
    check("exp0", v, 16'h0064);
    rd(IDX_NPTX, v);
    check("nptx0", v, 16'h2001);
    check("np_tx0", {1'b0, np_tx}, 16'h2001);
  endtask : t_reset
  // a write while the clock enable is low must leave the register alone
  task automatic t_ce();
    logic [15:0] v;
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(IDX_NPTX, 16'hFFFF);
    ce <= 1'b1;
    rd(IDX_NPTX, v);
    check("nptx_ce", v, 16'h2001);
  endtask : t_ce
  task automatic t_write();
    logic [15:0] v;
    wr(IDX_NPTX, 16'hFFFF);
    rd(IDX_NPTX, v);
    check("nptx1", v, 16'hB7FF);
    check("np_tx1", {1'b0, np_tx}, 16'h77FF);
    wr(IDX_NPTX, 16'h0000);
    rd(IDX_NPTX, v);
    check("nptx2", v, 16'h0000);
  endtask : t_write
  task automatic t_toggle();
    logic [15:0] v;
    lp.pulse(2, 1'b0);
    rd(IDX_NPTX, v);
    check("tog_lo", v, 16'h0800);
    lp.pulse(2, 1'b1);
    rd(IDX_NPTX, v);
    check("tog_hi", v, 16'h0000);
  endtask : t_toggle
  task automatic t_able();
    logic [15:0] v;
    lp.set_able(1'b1, 1'b1);
    rd(IDX_EXP, v);
    check("able1", v, 16'h006D);
    lp.set_able(1'b0, 1'b0);
    rd(IDX_EXP, v);
    check("able0", v, 16'h0064);
  endtask : t_able
  task automatic t_latch();
    logic [15:0] v;
    lp.pulse(0, 1'b0);
    rd(IDX_EXP, v);
    check("pg_set", v, 16'h0066);
    rd(IDX_EXP, v);
    check("pg_clr", v, 16'h0064);
    lp.pulse(1, 1'b0);
    rd(IDX_EXP, v);
    check("pd_set", v, 16'h0074);
    rd(IDX_EXP, v);
    check("pd_clr", v, 16'h0064);
    // event in the very cycle of the clearing read must survive it
    fork
      rd(IDX_EXP, v);
      lp.pulse(0, 1'b0);
    join
    check("pg_race0", v, 16'h0064);
    rd(IDX_EXP, v);
    check("pg_race1", v, 16'h0066);
    fork
      rd(IDX_EXP, v);
      lp.pulse(1, 1'b0);
    join
    check("pd_race0", v, 16'h0064);
    rd(IDX_EXP, v);
    check("pd_race1", v, 16'h0074);
  endtask : t_latch
  task automatic t_irq();
    logic [15:0] v;
    wr(IDX_IRQ_CLR, 16'h000F);
    wr(IDX_IRQ_EN, 16'h0002);
    lp.pulse(0, 1'b0);
    #1 check("irq_mask", {15'h0000, irq}, 16'h0000);
    rd(IDX_IRQ_STAT, v);
    check("irq_stat", v, 16'h0001);
    wr(IDX_IRQ_EN, 16'h0003);
    #1 check("irq_on", {15'h0000, irq}, 16'h0001);
    wr(IDX_IRQ_CLR, 16'h0001);
    #1 check("irq_off", {15'h0000, irq}, 16'h0000);
    rd(IDX_IRQ_EN, v);
    check("irq_en", v, 16'h0003);
    rd(IDX_IRQ_CLR, v);
    check("irq_clr_rd", v, 16'h0000);
    rd(5'h1F, v);
    check("unmapped", v, 16'h0000);
    // sent page and partner arrival land in the upper status bits
    lp.pulse(2, 1'b0);
    lp.set_able(1'b1, 1'b0);
    rd(IDX_IRQ_STAT, v);
    check("irq_ev", v, 16'h000C);
    // an event in the clearing cycle must survive the clear
    fork
      wr(IDX_IRQ_CLR, 16'h000F);
      lp.pulse(1, 1'b0);
    join
    #1 check("irq_race", {15'h0000, irq}, 16'h0001);
    rd(IDX_IRQ_STAT, v);
    check("irq_race_st", v, 16'h0002);
  endtask : t_irq

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst_b = 1'b0;
    ce    = 1'b1;
    bus   = '0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_ce();
    t_write();
    t_toggle();
    t_able();
    t_latch();
    t_irq();
    finish_test();
  end
  // the whole sequence needs well under a few hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
